/* rtl/sradm_pkg.sv */
// constants shared by the serial register access port with dual memory
// =====================================================================
// Notes on behaviour
// - port live only while chip select low
// - command bits sampled on serial clock rise
// - response bits shifted out on clock fall
// - output driven only while chip select low
// - shifted data is the earlier requested register
// - 16-bit registers, separate upper and lower byte addresses
// - control settings come from working sram copy
// - only backed registers stored and restored
// - word 0xBE40 copies backed registers to flash
// - flash loads into sram after every reset
// - mode 3, 16-bit frames, msb first
// - read: address frame, data in next frame
// - write frame updates one byte at 16th edge
package sradm_pkg;
    // =================================================================
    // frame layout
    localparam int          FRAME_BITS  = 16;
    localparam int          CNT_W       = 5;
    localparam logic [4:0]  LAST_BIT    = 5'h10;
    localparam int          WR_FLAG_POS = 15;
    localparam int          ADDR_MSB    = 14;
    localparam int          ADDR_LSB    = 8;
    localparam int          DATA_MSB    = 7;
    // =================================================================
    // register bank
    localparam int          NUM_REGS    = 64;
    localparam int          IDX_W       = 6;
    localparam logic [5:0]  LAST_IDX    = 6'h3F;
    localparam logic [6:0]  CMD_ADDR_HI = 7'h3F;
    localparam int          FLASH_UPD_BIT = 6;
    localparam logic [15:0] IDLE_WORD   = 16'h0000;
    // one bit per register: set where the register has a flash copy
    localparam logic [63:0] FLASH_BACKED = 64'h0000_0000_0100_E00F;
    // =================================================================
    // minimum host gap between frames, kept for reference
    localparam real         STALL_US    = 16.5;
    // =================================================================
    // memory sequencer states
    typedef enum logic [1:0] {
        SRADM_LOAD,
        SRADM_IDLE,
        SRADM_STORE
    } sradm_state_t;
endpackage : sradm_pkg

/* rtl/sradm_spi_slave.sv */
// serial slave port with sram register bank and flash backup copy
module sradm_spi_slave
    import sradm_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        cs_n,
    input  wire logic        sclk,
    input  wire logic        din,
    output logic             dout,
    output logic             dout_oe,
    input  wire logic [5:0]  ctrl_idx,
    output logic [15:0]      ctrl_data,
    input  wire logic        prod_we,
    input  wire logic [5:0]  prod_idx,
    input  wire logic [15:0] prod_data,
    output logic             cfg_ready,
    output logic             flash_busy
);

    // =================================================================
    // storage
    logic [15:0] sram_reg [NUM_REGS];
    // flash starts erased in simulation; contents survive reset
    logic [15:0] flash_mem [NUM_REGS] = '{default: 16'h0000};

    // =================================================================
    // pin synchronisers
    logic cs_s1_reg;
    logic cs_s2_reg;
    logic sclk_s1_reg;
    logic sclk_s2_reg;
    logic sclk_s3_reg;
    logic din_s1_reg;
    logic din_s2_reg;

    // two flops per pin, third sclk stage only for edge finding
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cs_s1_reg   <= 1'b1;
            cs_s2_reg   <= 1'b1;
            sclk_s1_reg <= 1'b1;
            sclk_s2_reg <= 1'b1;
            sclk_s3_reg <= 1'b1;
            din_s1_reg  <= 1'b0;
            din_s2_reg  <= 1'b0;
        end else begin
            cs_s1_reg   <= cs_n;
            cs_s2_reg   <= cs_s1_reg;
            sclk_s1_reg <= sclk;
            sclk_s2_reg <= sclk_s1_reg;
            sclk_s3_reg <= sclk_s2_reg;
            din_s1_reg  <= din;
            din_s2_reg  <= din_s1_reg;
        end
    end

    logic active;
    logic sclk_rise;
    logic sclk_fall;

    // edges only count while selected
    assign active    = ~cs_s2_reg;
    assign sclk_rise = active & sclk_s2_reg & ~sclk_s3_reg;
    assign sclk_fall = active & ~sclk_s2_reg & sclk_s3_reg;

    // =================================================================
    // receive side
    logic [15:0]      rx_reg;
    logic [CNT_W-1:0] rx_cnt_reg;
    logic [15:0]      rx_word;
    logic             frame_done;

    assign rx_word    = {rx_reg[14:0], din_s2_reg};
    assign frame_done = sclk_rise && (rx_cnt_reg == LAST_BIT - 5'h01);

    // msb first shift on each rising edge, count restarts per frame
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rx_reg     <= 16'h0000;
            rx_cnt_reg <= '0;
        end else if (!active) begin
            rx_cnt_reg <= '0;
        end else if (sclk_rise) begin
            rx_reg <= rx_word;
            if (frame_done) begin
                rx_cnt_reg <= '0;
            end else begin
                rx_cnt_reg <= rx_cnt_reg + 5'h01;
            end
        end
    end

    // =================================================================
    // command decode of a finished frame
    logic             is_write;
    logic [6:0]       cmd_addr;
    logic [7:0]       cmd_data;
    logic [IDX_W-1:0] cmd_idx;
    logic             seq_idle;
    logic             reg_write;
    logic             flash_cmd;

    assign is_write  = rx_word[WR_FLAG_POS];
    assign cmd_addr  = rx_word[ADDR_MSB:ADDR_LSB];
    assign cmd_data  = rx_word[DATA_MSB:0];
    assign cmd_idx   = cmd_addr[6:1];
    // global command pair is a trigger, never stored; the update bit
    // sits in its lower byte, so the even address of the pair fires it
    assign flash_cmd = frame_done && is_write && seq_idle
                       && (cmd_idx == CMD_ADDR_HI[6:1])
                       && !cmd_addr[0]
                       && cmd_data[FLASH_UPD_BIT];
    assign reg_write = frame_done && is_write && seq_idle
                       && (cmd_idx != CMD_ADDR_HI[6:1]);

    // =================================================================
    // transmit side
    logic [15:0]      rd_word_reg;
    logic [15:0]      tx_reg;
    logic [CNT_W-1:0] tx_cnt_reg;
    logic             out_bit_reg;

    // read frame latches the addressed word for the next frame
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rd_word_reg <= IDLE_WORD;
        end else if (frame_done) begin
            if (!is_write) begin
                rd_word_reg <= sram_reg[cmd_idx];
            end else begin
                rd_word_reg <= IDLE_WORD;
            end
        end
    end

    // first falling edge of a frame loads, later ones shift
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tx_reg      <= 16'h0000;
            tx_cnt_reg  <= '0;
            out_bit_reg <= 1'b0;
        end else if (!active) begin
            tx_cnt_reg <= '0;
        end else if (sclk_fall) begin
            if (tx_cnt_reg == '0) begin
                out_bit_reg <= rd_word_reg[15];
                tx_reg      <= {rd_word_reg[14:0], 1'b0};
            end else begin
                out_bit_reg <= tx_reg[15];
                tx_reg      <= {tx_reg[14:0], 1'b0};
            end
            if (tx_cnt_reg == LAST_BIT - 5'h01) begin
                tx_cnt_reg <= '0;
            end else begin
                tx_cnt_reg <= tx_cnt_reg + 5'h01;
            end
        end
    end

    // drive only while selected; the pad floats otherwise
    assign dout    = out_bit_reg;
    assign dout_oe = active;

    // =================================================================
    // memory sequencer: load after reset, store on command
    sradm_state_t     state_reg;
    logic [IDX_W-1:0] seq_idx_reg;
    logic             seq_last;

    assign seq_idle = (state_reg == SRADM_IDLE);
    assign seq_last = (seq_idx_reg == LAST_IDX);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_reg   <= SRADM_LOAD;
            seq_idx_reg <= '0;
        end else begin
            case (state_reg)
                SRADM_LOAD: begin
                    seq_idx_reg <= seq_idx_reg + 6'h01;
                    if (seq_last) begin
                        state_reg <= SRADM_IDLE;
                    end
                end
                SRADM_IDLE: begin
                    seq_idx_reg <= '0;
                    if (flash_cmd) begin
                        state_reg <= SRADM_STORE;
                    end
                end
                SRADM_STORE: begin
                    seq_idx_reg <= seq_idx_reg + 6'h01;
                    if (seq_last) begin
                        state_reg <= SRADM_IDLE;
                    end
                end
                default: begin
                    state_reg <= SRADM_IDLE;
                end
            endcase
        end
    end

    // =================================================================
    // flash array: written only by the store walk
    always_ff @(posedge clock) begin
        if (state_reg == SRADM_STORE && FLASH_BACKED[seq_idx_reg]) begin
            flash_mem[seq_idx_reg] <= sram_reg[seq_idx_reg];
        end
    end

    // =================================================================
    // sram bank, one generate entry per register
    for (genvar g = 0; g < NUM_REGS; g++) begin : g_sram
        localparam logic [5:0] IDX = 6'(g);
        always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
                sram_reg[g] <= 16'h0000;
            end else if (state_reg == SRADM_LOAD && seq_idx_reg == IDX) begin
                if (FLASH_BACKED[g]) begin
                    sram_reg[g] <= flash_mem[g];
                end else begin
                    sram_reg[g] <= 16'h0000;
                end
            end else if (reg_write && cmd_idx == IDX) begin
                if (cmd_addr[0]) begin
                    sram_reg[g][15:8] <= cmd_data;
                end else begin
                    sram_reg[g][7:0] <= cmd_data;
                end
            end else if (prod_we && seq_idle && prod_idx == IDX) begin
                sram_reg[g] <= prod_data;   // results from the data path
            end
        end
    end

    // =================================================================
    // user side: settings always come from the sram copy
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_data <= 16'h0000;
        end else begin
            ctrl_data <= sram_reg[ctrl_idx];
        end
    end

    // data production may start once the load walk has finished
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cfg_ready  <= 1'b0;
            flash_busy <= 1'b0;
        end else begin
            cfg_ready  <= (state_reg != SRADM_LOAD);
            flash_busy <= (state_reg == SRADM_STORE);
        end
    end

endmodule : sradm_spi_slave

/* tb/spi_register_access_dual_memory_tb.sv */
// bench for the serial register port with sram and flash copy
module spi_register_access_dual_memory_tb import sradm_pkg::*;;
    timeunit 1ns / 1ps;
    logic        clock = 1'b0, arst_n = 1'b0, prod_we = 1'b0;
    logic        cs_n, sclk, din, dout, dout_oe, cfg_ready, flash_busy;
    logic [5:0]  ctrl_idx = 6'h00, prod_idx = 6'h00;
    logic [15:0] ctrl_data, prod_data = 16'h0000;
    logic [15:0] sram_m [64], flash_m [64];
    logic [31:0] seed = 32'h1587122B;
    int          err_total = 0, checked = 0, cycles = 0, busy_cyc = 0;
    always #5 clock = ~clock;
    sradm_spi_slave uut (.clock(clock), .arst_n(arst_n), .cs_n(cs_n),
        .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe),
        .ctrl_idx(ctrl_idx), .ctrl_data(ctrl_data), .prod_we(prod_we),
        .prod_idx(prod_idx), .prod_data(prod_data),
        .cfg_ready(cfg_ready), .flash_busy(flash_busy));
    sradm_host_model host (.clock(clock), .dout(dout),
        .dout_oe(dout_oe), .cs_n(cs_n), .sclk(sclk), .din(din));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checked++;
        if (seen !== want) begin
            err_total++;
            $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    task automatic give_verdict;
        $display("checked=%0d err_total=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    // reset, then expect flash copy in backed words and zero elsewhere
    task automatic rst;
        @(negedge clock);
        arst_n = 1'b0;
        repeat (4) @(negedge clock);
        check({13'h0, cfg_ready, flash_busy, dout_oe}, 16'h0000);
        check(ctrl_data, 16'h0000);
        arst_n = 1'b1;
        for (int i = 0; i < 64; i++)
            sram_m[i] = FLASH_BACKED[i] ? flash_m[i] : 16'h0000;
        for (int n = 0; n < 200 && cfg_ready !== 1'b1; n++) @(negedge clock);
        check({15'h0, cfg_ready}, 16'h0001);
    endtask : rst
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [15:0] r;
        host.xfer({1'b1, a, d}, r);
        if (a[0]) sram_m[a[6:1]][15:8] = d;
        else sram_m[a[6:1]][7:0] = d;
    endtask : wr
    // serial read in two frames, then the user-side copy
    task automatic rd(input logic [5:0] i);
        logic [15:0] r;
        host.xfer({1'b0, i, 1'b0, 8'h00}, r);
        host.xfer(16'h0000, r);
        check(r, sram_m[i]);
        @(negedge clock);
        ctrl_idx = i;
        @(negedge clock);
        check(ctrl_data, sram_m[i]);
    endtask : rd
    always @(posedge clock) begin
        cycles++;
        if (flash_busy === 1'b1) busy_cyc++;
        if (cycles == 90000) begin
            err_total++;
            give_verdict();
        end
    end
    initial begin
        logic [15:0] r;
        logic [6:0]  a;
        for (int i = 0; i < 64; i++) flash_m[i] = 16'h0000;
        rst();
        wr(7'h01, 8'hA5);
        wr(7'h00, 8'h3C);
        rd(6'h00);
        for (int k = 0; k < 6; k++) begin
            seed = xs(seed);
            a = seed[6:0] % 7'h3E; // keeps off the command byte pair
            wr(a, seed[15:8]);
            rd(a[6:1]);
        end
        // producer write shows up on the serial read
        @(negedge clock);
        prod_we = 1'b1;
        prod_idx = 6'h0A;
        prod_data = seed[31:16];
        @(negedge clock);
        prod_we = 1'b0;
        sram_m[10] = prod_data;
        rd(6'h0A);
        // store a backed and a plain word, then reload through reset
        wr(7'h02, 8'h5A);
        wr(7'h08, 8'hC3);
        host.xfer(16'hBE40, r);
        check({15'h0, flash_busy}, 16'h0000);
        check(busy_cyc[15:0], 16'(NUM_REGS));
        for (int i = 0; i < 64; i++)
            if (FLASH_BACKED[i]) flash_m[i] = sram_m[i];
        rst();
        rd(6'h01);
        rd(6'h04);
        give_verdict();
    end
endmodule : spi_register_access_dual_memory_tb

/* tb/sradm_host_model.sv */
// host model: mode 3 serial master with stall gap
module sradm_host_model (
    input  wire logic clock,
    input  wire logic dout,
    input  wire logic dout_oe,
    output logic      cs_n,
    output logic      sclk,
    output logic      din
);
    timeunit 1ns / 1ps;
    logic last_bit = 1'b0;
    logic miso;
    // released line shows the inverse of the last driven level
    assign miso = dout_oe ? dout : ~last_bit;
    always @(posedge clock) if (dout_oe) last_bit <= dout;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        din = 1'b0;
    end
    task automatic half;
        repeat (8) @(negedge clock);
    endtask : half
    // one 16-bit frame, msb first, sclk idles high
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        @(negedge clock);
        cs_n = 1'b0;
        half();
        for (int i = 15; i >= 0; i--) begin
            sclk = 1'b0;
            din = tx[i];
            half();
            rx[i] = miso;
            sclk = 1'b1;
            half();
        end
        cs_n = 1'b1;
        repeat (1650) @(negedge clock);
    endtask : xfer
endmodule : sradm_host_model

/* tb/sradm_spi_checker.sv */
// checker for the serial register port, bound to its ports
module sradm_spi_checker (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic cfg_ready,
    input wire logic flash_busy
);
    timeunit 1ns / 1ps;
    logic [6:0] since_rst;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    // =========================================================
    // cycles since reset release, saturating
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) since_rst <= 7'h00;
        else if (since_rst != 7'h7F) since_rst <= since_rst + 7'h01;
    end
    property p_oe_off; cs_n[*3] |-> !dout_oe; endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("data out driven while deselected");
    property p_oe_on; (!cs_n)[*3] |-> dout_oe; endproperty
    a_oe_on: assert property (p_oe_on)
        else $error("data out not driven while selected");
    property p_dout_fall;
        dout_oe && $past(dout_oe) && $changed(dout) |-> !sclk;
    endproperty
    a_dout_fall: assert property (p_dout_fall)
        else $error("data out moved while serial clock high");
    property p_ready_min; cfg_ready |-> since_rst >= 7'h3F; endproperty
    a_ready_min: assert property (p_ready_min)
        else $error("ready before the load walk ended");
    property p_ready_by; since_rst == 7'h50 |-> cfg_ready; endproperty
    a_ready_by: assert property (p_ready_by)
        else $error("ready late after reset");
    property p_busy_ready; flash_busy |-> cfg_ready; endproperty
    a_busy_ready: assert property (p_busy_ready)
        else $error("store began before load ended");
    property p_busy_hold; $rose(flash_busy) |-> flash_busy[*8]; endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("store walk too short");
    property p_busy_end;
        $rose(flash_busy) |-> ##[60:70] !flash_busy;
    endproperty
    a_busy_end: assert property (p_busy_end)
        else $error("store walk did not end");
endmodule : sradm_spi_checker

bind sradm_spi_slave sradm_spi_checker u_chk (
    .clock(clock), .arst_n(arst_n), .cs_n(cs_n), .sclk(sclk),
    .dout(dout), .dout_oe(dout_oe), .cfg_ready(cfg_ready),
    .flash_busy(flash_busy));
